// File: rtl/ecp_pkg.sv
// constants for the pcm serial port and power-down block
// assumes one 125 MHz system clock and a synchronous active-high reset
package ecp_pkg;
   localparam int unsigned CLK_PERIOD_NS   = 8;
   localparam int unsigned SYS_CLK_HZ      = 125_000_000;
   localparam int unsigned GEN_BCLK_HZ     = 200_000;
   localparam int unsigned FRAME_HZ        = 8_000;
   localparam int unsigned INIT_TIME_NS    = 100_000;
   // least time, rounded up to whole cycles
   localparam int unsigned INIT_CYCLES     = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // half period of the generated bit clock, rounded down
   localparam int unsigned GEN_HALF_CYCLES = SYS_CLK_HZ / (2 * GEN_BCLK_HZ);
   localparam int unsigned GEN_BITS_FRAME  = GEN_BCLK_HZ / FRAME_HZ;

   localparam int unsigned SAMPLE_BITS     = 8;
   localparam int unsigned CASC_BITS       = 16;
   localparam int unsigned BUF_DEPTH       = 2;
   localparam int unsigned INIT_W          = 14;
   localparam int unsigned DIV_W           = 9;
   localparam int unsigned GBIT_W          = 5;

   // positions of the pin inputs in the synchroniser vector
   localparam int unsigned PIN_BCLK   = 0;
   localparam int unsigned PIN_SYNC   = 1;
   localparam int unsigned PIN_RX     = 2;
   localparam int unsigned PIN_STROBE = 3;
   localparam int unsigned PIN_PDN    = 4;
   localparam int unsigned PIN_W      = 5;

   localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(GEN_HALF_CYCLES - 1);
   localparam logic [GBIT_W-1:0] GBIT_LAST = GBIT_W'(GEN_BITS_FRAME - 1);
   localparam logic [2:0]        BIT_LAST  = 3'(SAMPLE_BITS - 1);
   localparam logic [1:0]        BUF_FULL  = 2'(BUF_DEPTH);

   typedef enum logic [1:0] {FR_IDLE, FR_SHIFT, FR_TAIL} ecp_frame_t;
endpackage

// File: rtl/ecp_pcm_port.sv
// pcm serial port, cascade bus latch and power-down control
// assumes all pins are asynchronous to sys_clk; the bit clock pin is sampled, not used as a clock
`timescale 1ns/1ps
// Behaviour
// R1: receive serial input sampled on each falling edge of the bit clock.
// R2: far side supplies a bit clock between 64 and 2048 kHz.
// R3: far side supplies an 8 kHz frame sync.
// R4: one bit clock and one sync time both serial directions.
// R5: both serial outputs drive mu-law samples timed by sync and bit clock.
// R6: serial outputs and cascade lines float whenever not driving data.
// R7: sixteen-line two-way cascade bus, line 15 is the msb.
// R8: cascade value latched on falling edge of the cascade strobe.
// R9: far side provides the 18 MHz basic clock.
// R10: power-down while input low; all other inputs ignored then. The code still takes buffer pushes and loads casc_tx_data into casc_out.
// R11: power-down floats outputs, drives generated clocks low, overflow flags high.
// R12: power-down holds test and load-detect outputs; oscillator outputs untouched.
// R13: after power-down release the device is reset before processing resumes.
// R14: generated 200 kHz bit clock, driven low in power-down.
// R15: after reset release all inputs but power-down ignored for 100 us. The code still passes overflow and test inputs and takes buffer pushes.
// R16: one 8-bit sample per direction per frame, msb first, after sync.
// R17: serial outputs change on the rising bit clock edge.
module ecp_pcm_port
   import ecp_pkg::*;
#(
   parameter int unsigned INIT_LEN = INIT_CYCLES
) (
   input  wire logic                   sys_clk,
   input  wire logic                   reset,
   input  wire logic                   bit_clk_in,
   input  wire logic                   frame_sync_in,
   input  wire logic                   rx_serial_in,
   input  wire logic                   power_down_n,
   output logic                        tx_serial_out,
   output logic                        tx_serial_oe_n,
   output logic                        rx_serial_out,
   output logic                        rx_serial_oe_n,
   output logic                        gen_bit_clock_out,
   output logic                        gen_frame_sync_out,
   input  wire logic [CASC_BITS-1:0]   cascade_bus_in,
   output logic      [CASC_BITS-1:0]   cascade_bus_out,
   output logic      [CASC_BITS-1:0]   cascade_bus_oe_n,
   input  wire logic                   cascade_strobe,
   input  wire logic                   casc_drive_req,
   input  wire logic [CASC_BITS-1:0]   casc_tx_data,
   output logic      [CASC_BITS-1:0]   casc_rx_data,
   output logic                        casc_rx_valid,
   input  wire logic                   out_valid,
   output logic                        out_ready,
   input  wire logic [SAMPLE_BITS-1:0] out_tx_sample,
   input  wire logic [SAMPLE_BITS-1:0] out_rx_sample,
   output logic      [SAMPLE_BITS-1:0] rx_sample,
   output logic                        rx_sample_valid,
   input  wire logic                   overflow_a_in,
   input  wire logic                   overflow_b_in,
   output logic                        overflow_flag_a,
   output logic                        overflow_flag_b,
   input  wire logic                   test_in,
   output logic                        test_output,
   output logic                        load_detect_out_n
);

   typedef struct packed {
      logic [PIN_W-1:0]                       s1;
      logic [PIN_W-1:0]                       s2;
      logic [PIN_W-1:0]                       s3;
      logic [PIN_W-1:0]                       lvl;
      logic [CASC_BITS-1:0]                   bus1;
      logic [CASC_BITS-1:0]                   bus2;
      logic [CASC_BITS-1:0]                   bus3;
      logic [INIT_W-1:0]                      init_cnt;
      logic [DIV_W-1:0]                       div_cnt;
      logic                                   gclk;
      logic [GBIT_W-1:0]                      gbit_cnt;
      logic                                   gsync;
      ecp_frame_t                             fstate;
      logic                                   arm;
      logic [2:0]                             bit_cnt;
      logic [SAMPLE_BITS-1:0]                 tx_sh;
      logic [SAMPLE_BITS-1:0]                 rxo_sh;
      logic [SAMPLE_BITS-1:0]                 rx_sh;
      logic                                   drive;
      logic [SAMPLE_BITS-1:0]                 rx_sample;
      logic                                   rx_valid;
      logic [CASC_BITS-1:0]                   casc_q;
      logic                                   casc_valid;
      logic                                   casc_drive;
      logic [CASC_BITS-1:0]                   casc_out;
      logic [BUF_DEPTH-1:0][2*SAMPLE_BITS-1:0] buf_data;
      logic [1:0]                             buf_cnt;
      logic                                   ovf_a;
      logic                                   ovf_b;
      logic                                   test_q;
      logic                                   load_n;
   } ecp_state_t;

   localparam logic [INIT_W-1:0] INIT_LOAD = INIT_W'(INIT_LEN);

   ecp_state_t st_q;
   ecp_state_t st_d;

   logic pd;
   logic ignore;
   logic bclk_rise;
   logic bclk_fall;
   logic sync_rise;
   logic strobe_fall;
   logic push;
   logic pop;

   function automatic logic rose(input logic prev, input logic nxt);
      return nxt & ~prev;
   endfunction

   always_comb begin
      st_d = st_q;
      st_d.rx_valid   = 1'b0;
      st_d.casc_valid = 1'b0;
      pop             = 1'b0;
      // three-stage synchronisers; a level counts once stages two and three agree
      st_d.s1   = {power_down_n, cascade_strobe, rx_serial_in, frame_sync_in, bit_clk_in};
      st_d.s2   = st_q.s1;
      st_d.s3   = st_q.s2;
      st_d.bus1 = cascade_bus_in;
      st_d.bus2 = st_q.bus1;
      st_d.bus3 = st_q.bus2;
      for (int i = 0; i < PIN_W; i++) begin
         if (st_q.s2[i] == st_q.s3[i]) begin
            st_d.lvl[i] = st_q.s3[i];
         end
      end
      bclk_rise   = rose(st_q.lvl[PIN_BCLK], st_d.lvl[PIN_BCLK]);
      bclk_fall   = rose(st_d.lvl[PIN_BCLK], st_q.lvl[PIN_BCLK]);
      sync_rise   = rose(st_q.lvl[PIN_SYNC], st_d.lvl[PIN_SYNC]);
      strobe_fall = rose(st_d.lvl[PIN_STROBE], st_q.lvl[PIN_STROBE]);
      pd          = ~st_q.lvl[PIN_PDN];                              // see R10
      ignore      = pd | (st_q.init_cnt != '0);                     // see R15

      // initialisation window restarts on power-down release as well
      if (pd) begin
         st_d.init_cnt = INIT_LOAD;                                  // see R13
      end else if (st_q.init_cnt != '0) begin
         st_d.init_cnt = st_q.init_cnt - 1'b1;                       // see R15
      end

      // generated codec clock and sync; sync spans one bit period per frame
      if (pd) begin
         st_d.gclk     = 1'b0;                                       // see R11
         st_d.gsync    = 1'b0;                                       // see R11
         st_d.div_cnt  = '0;
         st_d.gbit_cnt = '0;
      end else if (st_q.div_cnt == DIV_LAST) begin
         st_d.div_cnt = '0;
         st_d.gclk    = ~st_q.gclk;                                  // see R14
         if (!st_q.gclk) begin
            st_d.gbit_cnt = (st_q.gbit_cnt == GBIT_LAST) ? '0 : st_q.gbit_cnt + 1'b1;
            st_d.gsync    = (st_q.gbit_cnt == GBIT_LAST);
         end
      end else begin
         st_d.div_cnt = st_q.div_cnt + 1'b1;
      end

      // frame engine: the sampled bit clock times both directions
      if (ignore) begin
         st_d.fstate  = FR_IDLE;
         st_d.arm     = 1'b0;
         st_d.drive   = 1'b0;                                        // see R6
         st_d.bit_cnt = '0;
      end else begin
         if (sync_rise) begin
            st_d.arm = 1'b1;                                         // see R3 R4
         end
         unique case (st_q.fstate)
            FR_IDLE, FR_TAIL: begin
               if (bclk_rise) begin
                  st_d.drive  = 1'b0;                                // see R6
                  st_d.fstate = FR_IDLE;
                  if (st_q.arm) begin
                     st_d.arm     = 1'b0;
                     st_d.fstate  = FR_SHIFT;                        // see R16
                     st_d.bit_cnt = '0;
                     // an empty buffer leaves the outputs floating for this frame
                     if (st_q.buf_cnt != '0) begin
                        pop         = 1'b1;
                        st_d.tx_sh  = st_q.buf_data[0][2*SAMPLE_BITS-1:SAMPLE_BITS];
                        st_d.rxo_sh = st_q.buf_data[0][SAMPLE_BITS-1:0];
                        st_d.drive  = 1'b1;                          // see R5
                     end
                  end
               end
            end
            FR_SHIFT: begin
               if (bclk_rise) begin
                  st_d.tx_sh  = {st_q.tx_sh[SAMPLE_BITS-2:0], 1'b0};  // see R17
                  st_d.rxo_sh = {st_q.rxo_sh[SAMPLE_BITS-2:0], 1'b0}; // see R17
               end
               if (bclk_fall) begin
                  st_d.rx_sh = {st_q.rx_sh[SAMPLE_BITS-2:0], st_q.lvl[PIN_RX]}; // see R1
                  if (st_q.bit_cnt == BIT_LAST) begin
                     st_d.rx_sample = {st_q.rx_sh[SAMPLE_BITS-2:0], st_q.lvl[PIN_RX]};
                     st_d.rx_valid  = 1'b1;                          // see R16
                     st_d.fstate    = FR_TAIL;
                  end else begin
                     st_d.bit_cnt = st_q.bit_cnt + 1'b1;
                  end
               end
            end
         endcase
      end

      // load detect marks the frame from sample load to the next rising bit clock
      if (!pd) begin
         if (st_d.rx_valid) begin
            st_d.load_n = 1'b0;
         end else if (bclk_rise) begin
            st_d.load_n = 1'b1;
         end
         st_d.test_q = test_in;
      end                                                            // see R12
      st_d.ovf_a = pd | overflow_a_in;                               // see R11
      st_d.ovf_b = pd | overflow_b_in;                               // see R11

      // cascade bus
      if (!ignore && strobe_fall) begin
         st_d.casc_q     = st_q.bus3;                                // see R8
         st_d.casc_valid = 1'b1;
      end
      st_d.casc_drive = ~ignore & casc_drive_req;                    // see R6
      if (casc_drive_req) begin
         st_d.casc_out = casc_tx_data;                               // see R7
      end

      // two-entry output buffer; pop shifts down before the push lands
      out_ready = (st_q.buf_cnt != BUF_FULL);
      push      = out_valid & out_ready;
      if (pop) begin
         st_d.buf_data[0] = st_q.buf_data[1];
      end
      if (push) begin
         st_d.buf_data[st_q.buf_cnt - {1'b0, pop}] = {out_tx_sample, out_rx_sample};
      end
      st_d.buf_cnt = st_q.buf_cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_q          <= '0;
         st_q.fstate   <= FR_IDLE;
         st_q.init_cnt <= INIT_LOAD;
         st_q.ovf_a    <= 1'b1;
         st_q.ovf_b    <= 1'b1;
         st_q.load_n   <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign tx_serial_out      = st_q.tx_sh[SAMPLE_BITS-1];
   assign rx_serial_out      = st_q.rxo_sh[SAMPLE_BITS-1];
   assign tx_serial_oe_n     = ~st_q.drive;
   assign rx_serial_oe_n     = ~st_q.drive;
   assign gen_bit_clock_out  = st_q.gclk;
   assign gen_frame_sync_out = st_q.gsync;
   assign cascade_bus_out    = st_q.casc_out;
   assign cascade_bus_oe_n   = {CASC_BITS{~st_q.casc_drive}};
   assign casc_rx_data       = st_q.casc_q;
   assign casc_rx_valid      = st_q.casc_valid;
   assign rx_sample          = st_q.rx_sample;
   assign rx_sample_valid    = st_q.rx_valid;
   assign overflow_flag_a    = st_q.ovf_a;
   assign overflow_flag_b    = st_q.ovf_b;
   assign test_output        = st_q.test_q;
   assign load_detect_out_n  = st_q.load_n;

   property p_pd_outputs;
      @(posedge sys_clk) disable iff (reset)
      pd |=> (tx_serial_oe_n && rx_serial_oe_n && cascade_bus_oe_n == '1
              && !gen_bit_clock_out && !gen_frame_sync_out
              && overflow_flag_a && overflow_flag_b);
   endproperty
   a_pd_outputs: assert property (p_pd_outputs) else $error("power-down output states wrong"); // see R11

   property p_pd_hold;
      @(posedge sys_clk) disable iff (reset)
      pd |=> ($stable(test_output) && $stable(load_detect_out_n));
   endproperty
   a_pd_hold: assert property (p_pd_hold) else $error("held outputs moved in power-down"); // see R12

   property p_init_quiet;
      @(posedge sys_clk) disable iff (reset)
      (st_q.init_cnt != '0) |=> (tx_serial_oe_n && !rx_sample_valid && !casc_rx_valid);
   endproperty
   a_init_quiet: assert property (p_init_quiet) else $error("activity during init window"); // see R15

   property p_pd_restart;
      @(posedge sys_clk) disable iff (reset)
      pd ##1 !pd |-> (st_q.init_cnt == INIT_LOAD);
   endproperty
   a_pd_restart: assert property (p_pd_restart) else $error("init not restarted after power-down"); // see R13

   property p_rx_sample;
      @(posedge sys_clk) disable iff (reset)
      (!ignore && bclk_fall && st_q.fstate == FR_SHIFT && st_q.bit_cnt == BIT_LAST)
      |=> (rx_sample_valid && rx_sample[0] == $past(st_q.lvl[PIN_RX])
           && rx_sample[SAMPLE_BITS-1:1] == $past(st_q.rx_sh[SAMPLE_BITS-2:0]));
   endproperty
   a_rx_sample: assert property (p_rx_sample) else $error("received sample wrong"); // see R1

   property p_tx_edge;
      @(posedge sys_clk) disable iff (reset)
      (!tx_serial_oe_n && $past(!tx_serial_oe_n) && $changed(tx_serial_out)) |-> $past(bclk_rise);
   endproperty
   a_tx_edge: assert property (p_tx_edge) else $error("serial output moved off rising edge"); // see R17

   property p_frame_start;
      @(posedge sys_clk) disable iff (reset)
      (!ignore && bclk_rise && st_q.arm && st_q.fstate != FR_SHIFT && st_q.buf_cnt != '0)
      |=> (!tx_serial_oe_n && !rx_serial_oe_n
           && tx_serial_out == $past(st_q.buf_data[0][2*SAMPLE_BITS-1])
           && rx_serial_out == $past(st_q.buf_data[0][SAMPLE_BITS-1]));
   endproperty
   a_frame_start: assert property (p_frame_start) else $error("frame did not start with msb"); // see R16

   property p_casc_latch;
      @(posedge sys_clk) disable iff (reset)
      (!ignore && strobe_fall) |=> (casc_rx_valid && casc_rx_data == $past(st_q.bus3));
   endproperty
   a_casc_latch: assert property (p_casc_latch) else $error("cascade value not latched"); // see R8

   property p_casc_float;
      @(posedge sys_clk) disable iff (reset)
      (cascade_bus_oe_n != '1) |-> ($past(casc_drive_req) && !$past(ignore));
   endproperty
   a_casc_float: assert property (p_casc_float) else $error("cascade driven without request"); // see R6

   property p_gclk_high;
      @(posedge sys_clk) disable iff (reset || pd)
      $rose(gen_bit_clock_out) |=> gen_bit_clock_out [*8];
   endproperty
   a_gclk_high: assert property (p_gclk_high) else $error("generated clock high phase short"); // see R14

endmodule

// File: dv/ecp_codec_model.sv
// behavioural pcm codec on the far side of the serial port
// assumes callers enter frame() 2 ns after a sys_clk rising edge
`timescale 1ns/1ps
module ecp_codec_model (
   input  wire logic sys_clk,
   input  wire logic tx_serial_out,
   input  wire logic tx_serial_oe_n,
   input  wire logic rx_serial_out,
   input  wire logic rx_serial_oe_n,
   output logic      bit_clk,
   output logic      frame_sync,
   output logic      rx_data
);
   logic [7:0] tx_got;
   logic [7:0] rxo_got;
   int         drive_cnt;

   initial begin
      bit_clk    = 1'b0;
      frame_sync = 1'b0;
      rx_data    = 1'b0;
   end

   // five sys_clk per half gives the 80 ns link clock
   task automatic half();
      repeat (5) @(posedge sys_clk);
      #2;
   endtask

   // the clock stands still between frames, so a design needing a free clock is caught
   task automatic frame(input logic [7:0] rx_byte);
      drive_cnt  = 0;
      frame_sync = 1'b1;
      half();
      for (int i = 7; i >= 0; i--) begin
         bit_clk = 1'b1;
         rx_data = rx_byte[i];
         half();
         tx_got[i]  = tx_serial_out;
         rxo_got[i] = rx_serial_out;
         if (!tx_serial_oe_n && !rx_serial_oe_n) drive_cnt++;
         bit_clk    = 1'b0;
         frame_sync = 1'b0;
         half();
      end
      bit_clk = 1'b1;
      half();
      bit_clk = 1'b0;
      // a released line shows the inverse, never a stale bit
      rx_data = ~rx_data;
      half();
   endtask
endmodule

// File: dv/tb_pcm_serial_port_power_down.sv
// self-checking bench for the pcm port, cascade latch and power-down
// assumes ecp_pkg and ecp_pcm_port compiled first, codec model beside it
`timescale 1ns/1ps
module tb_pcm_serial_port_power_down;
   import ecp_pkg::*;
   localparam int unsigned INIT_SIM = 50;
   typedef struct packed {logic [7:0] tx; logic [7:0] rxo; logic [7:0] rxi;} ecp_row_t;

   logic                   sys_clk, reset, bit_clk_in, frame_sync_in, rx_serial_in;
   logic                   power_down_n, tx_serial_out, tx_serial_oe_n, rx_serial_out;
   logic                   rx_serial_oe_n, gen_bit_clock_out, gen_frame_sync_out;
   logic                   cascade_strobe, casc_drive_req, casc_rx_valid, out_valid;
   logic                   out_ready, rx_sample_valid, overflow_a_in, overflow_b_in;
   logic                   overflow_flag_a, overflow_flag_b, test_in, test_output;
   logic                   load_detect_out_n, ld_low;
   logic [CASC_BITS-1:0]   cascade_bus_in, cascade_bus_out, cascade_bus_oe_n;
   logic [CASC_BITS-1:0]   casc_tx_data, casc_rx_data, casc_ext, casc_got;
   logic [SAMPLE_BITS-1:0] out_tx_sample, out_rx_sample, rx_sample, rx_got;
   int                     failures, n_compared, rx_cnt, casc_cnt, n;
   ecp_row_t               rows [4] = '{'{8'hA5, 8'h5A, 8'hC3}, '{8'h00, 8'hFF, 8'h80},
                                        '{8'hFF, 8'h00, 8'h01}, '{8'h81, 8'h7E, 8'h3C}};

   // wire level of the two-way cascade lines
   assign cascade_bus_in = (cascade_bus_oe_n & casc_ext) | (~cascade_bus_oe_n & cascade_bus_out);

   ecp_pcm_port #(.INIT_LEN(INIT_SIM)) dut (
      .sys_clk, .reset, .bit_clk_in, .frame_sync_in, .rx_serial_in, .power_down_n,
      .tx_serial_out, .tx_serial_oe_n, .rx_serial_out, .rx_serial_oe_n,
      .gen_bit_clock_out, .gen_frame_sync_out, .cascade_bus_in, .cascade_bus_out,
      .cascade_bus_oe_n, .cascade_strobe, .casc_drive_req, .casc_tx_data, .casc_rx_data,
      .casc_rx_valid, .out_valid, .out_ready, .out_tx_sample, .out_rx_sample, .rx_sample,
      .rx_sample_valid, .overflow_a_in, .overflow_b_in, .overflow_flag_a, .overflow_flag_b,
      .test_in, .test_output, .load_detect_out_n);

   ecp_codec_model codec (
      .sys_clk, .tx_serial_out, .tx_serial_oe_n, .rx_serial_out, .rx_serial_oe_n,
      .bit_clk(bit_clk_in), .frame_sync(frame_sync_in), .rx_data(rx_serial_in));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      if (rx_sample_valid === 1'b1) begin
         rx_cnt++;
         rx_got = rx_sample;
         ld_low = load_detect_out_n;
      end
      if (casc_rx_valid === 1'b1) begin
         casc_cnt++;
         casc_got = casc_rx_data;
      end
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cycles(input int k);
      repeat (k) @(posedge sys_clk);
      #2;
   endtask

   // holds valid until out_ready is seen at an edge, then lets an idle edge pass
   task automatic push(input logic [7:0] t, input logic [7:0] r);
      int k = 0;
      out_tx_sample = t;
      out_rx_sample = r;
      out_valid     = 1'b1;
      while (out_ready !== 1'b1 && k < 500) begin
         cycles(1);
         k++;
      end
      if (k >= 500) failures++;
      cycles(1);
      out_valid = 1'b0;
      cycles(1);
   endtask

   task automatic casc_latch(input logic [15:0] v);
      casc_ext       = v;
      cascade_strobe = 1'b1;
      cycles(4);
      cascade_strobe = 1'b0;
      cycles(8);
      cascade_strobe = 1'b1;
      cycles(1);
   endtask

   task automatic wait_gen(input logic v);
      int k = 0;
      while (gen_bit_clock_out !== v && k < 2000) begin
         cycles(1);
         k++;
      end
      if (k >= 2000) failures++;
   endtask

   task automatic complete_run();
      $display("compared %0d mismatched %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge sys_clk);
      failures++;
      $display("watchdog expired");
      complete_run();
   end

   initial begin
      {reset, power_down_n, cascade_strobe} = 3'h7;
      {casc_drive_req, out_valid, overflow_a_in, overflow_b_in, test_in} = 5'h00;
      {casc_ext, casc_tx_data, out_tx_sample, out_rx_sample} = '0;
      {failures, n_compared, rx_cnt, casc_cnt} = '0;
      cycles(5);
      check("reset oe", 16'h0003, {14'h0000, tx_serial_oe_n, rx_serial_oe_n});
      check("reset flags", 16'h0003, {14'h0000, overflow_flag_a, overflow_flag_b});
      check("reset test and load", 16'h0001, {14'h0000, test_output, load_detect_out_n});
      check("reset cascade oe", 16'hFFFF, cascade_bus_oe_n);
      reset = 1'b0;
      casc_latch(16'h1234);
      check("strobe in init", 16'h0000, 16'(casc_cnt));
      cycles(INIT_SIM + 10);
      foreach (rows[i]) begin
         push(rows[i].tx, rows[i].rxo);
         codec.frame(rows[i].rxi);
         check("tx sample", 16'(rows[i].tx), 16'(codec.tx_got));
         check("rx out sample", 16'(rows[i].rxo), 16'(codec.rxo_got));
         check("rx sample", 16'(rows[i].rxi), 16'(rx_got));
         check("rx count", 16'(i + 1), 16'(rx_cnt));
         check("driven bits", 16'h0008, 16'(codec.drive_cnt));
         check("oe after frame", 16'h0003, {14'h0000, tx_serial_oe_n, rx_serial_oe_n});
         check("load detect", 16'h0000, 16'(ld_low));
      end
      codec.frame(8'h6C);
      check("empty buffer drive", 16'h0000, 16'(codec.drive_cnt));
      check("rx without entry", 16'h006C, 16'(rx_got));
      push(8'h11, 8'h22);
      push(8'h33, 8'h44);
      check("ready when full", 16'h0000, 16'(out_ready));
      codec.frame(8'h00);
      check("first entry", 16'h1122, {codec.tx_got, codec.rxo_got});
      cycles(30);
      codec.frame(8'h00);
      check("second entry", 16'h3344, {codec.tx_got, codec.rxo_got});
      check("ready when empty", 16'h0001, 16'(out_ready));
      casc_latch(16'h8001);
      check("cascade latch", 16'h8001, casc_got);
      casc_tx_data   = 16'hC35A;
      casc_drive_req = 1'b1;
      cycles(2);
      check("cascade drive oe", 16'h0000, cascade_bus_oe_n);
      check("cascade drive data", 16'hC35A, cascade_bus_out);
      casc_drive_req = 1'b0;
      {overflow_a_in, overflow_b_in, test_in} = 3'h5;
      cycles(3);
      check("cascade released", 16'hFFFF, cascade_bus_oe_n);
      check("flags", 16'h0005, {13'h0000, overflow_flag_a, overflow_flag_b, test_output});
      wait_gen(1'b0);
      wait_gen(1'b1);
      n = 0;
      while (gen_bit_clock_out === 1'b1 && n < 2000) begin
         cycles(1);
         n++;
      end
      check("gen clock half", 16'(GEN_HALF_CYCLES), 16'(n));
      // generated sync stands high for one whole generated bit period
      n = 0;
      while (gen_frame_sync_out !== 1'b1 && n < 20000) begin
         cycles(1);
         n++;
      end
      n = 0;
      while (gen_frame_sync_out === 1'b1 && n < 2000) begin
         cycles(1);
         n++;
      end
      check("gen sync width", 16'(2 * GEN_HALF_CYCLES), 16'(n));
      power_down_n = 1'b0;
      cycles(8);
      {overflow_a_in, overflow_b_in, test_in, casc_drive_req} = 4'h0;
      cycles(3);
      check("pd oe", 16'h0003, {14'h0000, tx_serial_oe_n, rx_serial_oe_n});
      check("pd cascade oe", 16'hFFFF, cascade_bus_oe_n);
      check("pd gen", 16'h0000, {14'h0000, gen_bit_clock_out, gen_frame_sync_out});
      check("pd flags", 16'h0007, {13'h0000, overflow_flag_a, overflow_flag_b, test_output});
      check("pd load hold", 16'h0001, 16'(load_detect_out_n));
      n = rx_cnt;
      casc_latch(16'h5555);
      codec.frame(8'h55);
      check("pd strobe", 16'h0001, 16'(casc_cnt));
      check("pd frame", 16'(n), 16'(rx_cnt));
      power_down_n = 1'b1;
      cycles(6);
      casc_latch(16'hAAAA);
      check("strobe after release", 16'h0001, 16'(casc_cnt));
      cycles(INIT_SIM + 10);
      casc_latch(16'h0F0F);
      check("latch after init", 16'h0F0F, casc_got);
      complete_run();
   end
endmodule
